// ### hw/scis_cmd_select.sv
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module scis_cmd_select #(
    parameter int AW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scis_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic zero_speed_clamp,
    input wire logic speed_sign_input,
    input wire logic torque_sign_input,
    input wire logic forced_alarm_input,
    input wire logic inertia_select_input,
    input wire logic signed [AW-1:0] analog_input_one,
    input wire logic signed [AW-1:0] analog_input_two,
    input wire logic signed [AW-1:0] analog_input_three,
    output logic signed [AW-1:0] speed_command,
    output logic signed [AW-1:0] torque_command,
    output logic signed [AW-1:0] speed_limit,
    output logic signed [AW-1:0] positive_torque_limit,
    output logic signed [AW-1:0] negative_torque_limit,
    output logic limit_from_param,
    output logic second_inertia_ratio,
    output logic forced_alarm_error,
    output logic [15:0] alarm_code
);
    import scis_pkg::*;

    localparam logic signed [AW-1:0] MAX_POS = {1'b0, {(AW-1){1'b1}}};
    localparam logic signed [AW-1:0] MIN_NEG = {1'b1, {(AW-1){1'b0}}};

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchroniser
    scis_sync_if #(.N(N_INPUTS)) sif ();
    assign sif.raw = {inertia_select_input, forced_alarm_input, torque_sign_input,
                      speed_sign_input, zero_speed_clamp};

    scis_sync #(.N(N_INPUTS)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // Magnitude with saturation so the most negative code cannot wrap
    function automatic logic signed [AW-1:0] mag(input logic signed [AW-1:0] v);
        logic signed [AW-1:0] r;
        if (v == MIN_NEG) begin
            r = MAX_POS;
        end else if (v < 0) begin
            r = -v;
        end else begin
            r = v;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // APB register file
    logic [31:0] config_ff, nxt_config;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic alarm_ff, nxt_alarm;
    logic wr_en, clr_req, mapped;

    // Ready is raised from the setup cycle, so every access completes in one wait-free cycle
    always_comb begin
        mapped = (paddr == ADDR_CONFIG) || (paddr == ADDR_STATUS) || (paddr == ADDR_ALARM_CLR);
        wr_en = psel && penable && pready_ff && pwrite && !pslverr_ff;
        clr_req = wr_en && (paddr == ADDR_ALARM_CLR) && pwdata[ALARM_CLR_BIT];
        nxt_config = config_ff;
        if (wr_en && (paddr == ADDR_CONFIG)) begin
            nxt_config = pwdata & CONFIG_MASK;
        end
        nxt_pready = psel && !penable;
        nxt_pslverr = psel && !penable && !mapped;
        nxt_prdata = prdata_ff;
        if (psel && !penable) begin
            unique case (paddr)
                ADDR_CONFIG: nxt_prdata = config_ff;
                ADDR_STATUS: begin
                    nxt_prdata = '0;
                    nxt_prdata[N_INPUTS-1:0] = sif.sync;
                    nxt_prdata[STAT_ALARM_BIT] = alarm_ff;
                    nxt_prdata[STAT_CODE_LSB +: 16] = alarm_code;
                end
                default: nxt_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_ff <= CONFIG_RESET;
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            config_ff <= nxt_config;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Command selection
    logic [CFG_ZCS_W-1:0] cfg_zcs;
    logic [CFG_TLS_W-1:0] cfg_tls;
    logic [CFG_SRC1_W-1:0] cfg_src1;
    logic cfg_sign_en, cfg_torque_mode, cfg_src2_torque, clamp_on;
    logic signed [AW-1:0] spd_ff, nxt_spd, trq_ff, nxt_trq, slim_ff, nxt_slim;
    logic signed [AW-1:0] ptl_ff, nxt_ptl, ntl_ff, nxt_ntl, spd_src, trq_src;
    logic param_ff, nxt_param, inertia_ff, nxt_inertia;
    logic [15:0] code_ff, nxt_code;

    assign cfg_zcs = config_ff[CFG_ZCS_LSB +: CFG_ZCS_W];
    assign cfg_tls = config_ff[CFG_TLS_LSB +: CFG_TLS_W];
    assign cfg_src1 = config_ff[CFG_SRC1_LSB +: CFG_SRC1_W];
    assign cfg_sign_en = config_ff[CFG_SIGN_EN_BIT];
    assign cfg_torque_mode = config_ff[CFG_TORQUE_MODE_BIT];
    assign cfg_src2_torque = config_ff[CFG_SRC2_BIT];
    assign clamp_on = sif.sync[IN_CLAMP] && (cfg_zcs != '0);

    // Routing, sign and clamp; unused code 3 of input one falls back to speed
    always_comb begin
        spd_src = (cfg_src1 == SRC1_TORQUE || cfg_src1 == SRC1_SPEED_LIMIT) ? '0 : analog_input_one;
        trq_src = (cfg_src1 == SRC1_TORQUE) ? analog_input_one
                : (cfg_src2_torque ? analog_input_two : '0);
        nxt_slim = (cfg_src1 == SRC1_SPEED_LIMIT) ? mag(analog_input_one) : '0;
        nxt_spd = spd_src;
        if (!cfg_torque_mode && cfg_sign_en) begin
            nxt_spd = sif.sync[IN_SSIGN] ? -mag(spd_src) : mag(spd_src);
        end
        if (clamp_on) begin
            nxt_spd = '0;
        end
        nxt_trq = trq_src;
        if (cfg_torque_mode) begin
            nxt_trq = sif.sync[IN_TSIGN] ? -mag(trq_src) : mag(trq_src);
        end
        nxt_param = 1'b0;
        nxt_ptl = '0;
        nxt_ntl = '0;
        unique case (cfg_tls)
            TLS_BIPOLAR: begin
                nxt_ptl = (analog_input_two < 0) ? '0 : analog_input_two;
                nxt_ntl = (analog_input_three > 0) ? '0 : mag(analog_input_three);
            end
            TLS_UNIPOLAR: begin
                nxt_ptl = (analog_input_two < 0) ? '0 : analog_input_two;
                nxt_ntl = (analog_input_three < 0) ? '0 : analog_input_three;
            end
            TLS_SHARED: begin
                nxt_ptl = (analog_input_two < 0) ? '0 : analog_input_two;
                nxt_ntl = nxt_ptl;
            end
            default: nxt_param = 1'b1;
        endcase
        nxt_inertia = sif.sync[IN_INERTIA];
        // A new trip in the clearing cycle keeps the alarm set
        nxt_alarm = sif.sync[IN_ALARM] || (alarm_ff && !clr_req);
        nxt_code = nxt_alarm ? {ALARM_MAIN_CODE, ALARM_SUB_CODE} : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_ff <= '0;
            trq_ff <= '0;
            slim_ff <= '0;
            ptl_ff <= '0;
            ntl_ff <= '0;
            param_ff <= 1'b0;
            inertia_ff <= 1'b0;
            alarm_ff <= 1'b0;
            code_ff <= '0;
        end else begin
            spd_ff <= nxt_spd;
            trq_ff <= nxt_trq;
            slim_ff <= nxt_slim;
            ptl_ff <= nxt_ptl;
            ntl_ff <= nxt_ntl;
            param_ff <= nxt_param;
            inertia_ff <= nxt_inertia;
            alarm_ff <= nxt_alarm;
            code_ff <= nxt_code;
        end
    end

    assign speed_command = spd_ff;
    assign torque_command = trq_ff;
    assign speed_limit = slim_ff;
    assign positive_torque_limit = ptl_ff;
    assign negative_torque_limit = ntl_ff;
    assign limit_from_param = param_ff;
    assign second_inertia_ratio = inertia_ff;
    assign forced_alarm_error = alarm_ff;
    assign alarm_code = code_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_clamp;
        sif.sync[IN_CLAMP] && (cfg_zcs != '0) |=> speed_command == '0;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp did not zero speed");

    property p_clamp_off;
        sif.sync[IN_CLAMP] && (cfg_zcs == '0) && !cfg_torque_mode && !cfg_sign_en && (cfg_src1 == SRC1_SPEED)
        |=> speed_command == $past(analog_input_one);
    endproperty
    a_clamp_off: assert property (p_clamp_off) else $error("clamp acted while disabled");

    property p_speed_sign;
        !clamp_on && !cfg_torque_mode && cfg_sign_en && sif.sync[IN_SSIGN] |=> speed_command <= 0;
    endproperty
    a_speed_sign: assert property (p_speed_sign) else $error("speed sign not negative");

    property p_torque_sign;
        cfg_torque_mode |=> ($past(sif.sync[IN_TSIGN]) ? (torque_command <= 0) : (torque_command >= 0));
    endproperty
    a_torque_sign: assert property (p_torque_sign) else $error("torque sign wrong");

    // A clear right after a one-cycle trip may legally end the alarm early, so that case is left out
    property p_alarm;
        $rose(sif.sync[IN_ALARM]) ##1 !clr_req
        |-> (forced_alarm_error && alarm_code == {ALARM_MAIN_CODE, ALARM_SUB_CODE}) [*2];
    endproperty
    a_alarm: assert property (p_alarm) else $error("forced alarm not raised");

    property p_inertia;
        ##1 second_inertia_ratio == $past(sif.sync[IN_INERTIA]);
    endproperty
    a_inertia: assert property (p_inertia) else $error("inertia bank mismatch");

    property p_route_three;
        (cfg_tls == TLS_UNIPOLAR) && (analog_input_three >= 0) |=> negative_torque_limit == $past(analog_input_three);
    endproperty
    a_route_three: assert property (p_route_three) else $error("input three not on negative limit");

    property p_shared;
        cfg_tls == TLS_SHARED |=> negative_torque_limit == positive_torque_limit && !limit_from_param;
    endproperty
    a_shared: assert property (p_shared) else $error("shared limit differs");

    property p_param;
        cfg_tls inside {3'h1, 3'h2, 3'h3, 3'h6} |=> limit_from_param && positive_torque_limit == '0;
    endproperty
    a_param: assert property (p_param) else $error("analog limit used in parameter mode");

    c_clamp: cover property (clamp_on ##1 speed_command == '0);
    c_alarm_clear: cover property (forced_alarm_error ##1 !forced_alarm_error);
    c_torque_neg: cover property (cfg_torque_mode && torque_command < 0);
    c_param: cover property (limit_from_param);
endmodule // scis_cmd_select

// ### hw/scis_pkg.sv
// Operation
// - While the clamp input is on and clamping is enabled, the speed command is forced to zero.
// - The clamp input acts only when the clamp function select setting is nonzero; software must program it.
// - In velocity control with sign selection enabled, the speed sign input sets the sign of the speed magnitude.
// - In torque control the torque command is negative when the torque sign input is on, positive when off.
// - The forced alarm input raises error 87.0 and puts the block in its alarm state.
// - The inertia select input picks the first inertia ratio when off and the second when on.
// - Analog input one feeds speed, torque or speed limit; input two torque or positive limit; three negative limit.
// - Limit source 0 uses both limit inputs with opposite ranges, 4 both positive ranges, 5 one input for both.
// - Limit sources 1, 2, 3 and 6 ignore analog limits and hand both limits to parameter-based selection.
package scis_pkg;
    // APB map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_CLR = 12'h008;
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] CONFIG_MASK = 32'h0000_1FFF;
    // Config fields
    localparam int CFG_ZCS_LSB = 0;
    localparam int CFG_ZCS_W = 4;
    localparam int CFG_TLS_LSB = 4;
    localparam int CFG_TLS_W = 3;
    localparam int CFG_SIGN_EN_BIT = 8;
    localparam int CFG_TORQUE_MODE_BIT = 9;
    localparam int CFG_SRC1_LSB = 10;
    localparam int CFG_SRC1_W = 2;
    localparam int CFG_SRC2_BIT = 12;
    // Analog input one function codes
    localparam logic [CFG_SRC1_W-1:0] SRC1_SPEED = 2'h0;
    localparam logic [CFG_SRC1_W-1:0] SRC1_TORQUE = 2'h1;
    localparam logic [CFG_SRC1_W-1:0] SRC1_SPEED_LIMIT = 2'h2;
    // Torque limit source codes
    localparam logic [CFG_TLS_W-1:0] TLS_BIPOLAR = 3'h0;
    localparam logic [CFG_TLS_W-1:0] TLS_UNIPOLAR = 3'h4;
    localparam logic [CFG_TLS_W-1:0] TLS_SHARED = 3'h5;
    // Status fields
    localparam int STAT_ALARM_BIT = 8;
    localparam int STAT_CODE_LSB = 16;
    localparam int ALARM_CLR_BIT = 0;
    // Forced alarm error code 87.0
    localparam logic [7:0] ALARM_MAIN_CODE = 8'h57;
    localparam logic [7:0] ALARM_SUB_CODE = 8'h00;
    // Digital input bit positions
    localparam int N_INPUTS = 5;
    localparam int IN_CLAMP = 0;
    localparam int IN_SSIGN = 1;
    localparam int IN_TSIGN = 2;
    localparam int IN_ALARM = 3;
    localparam int IN_INERTIA = 4;
    localparam int SYNC_STAGES = 2;
endpackage

// ### hw/scis_sync.sv
`timescale 1ns/1ps
module scis_sync #(
    parameter int N = 5
) (
    input wire logic pclk,
    input wire logic presetn,
    scis_sync_if.sync_side sif
);
    import scis_pkg::*;

    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;
    logic [N-1:0] nxt_meta;
    logic [N-1:0] nxt_sync;

    // First stage feeds only the second stage
    always_comb begin
        nxt_meta = sif.raw;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sif.sync = sync_ff;

    property p_sync_lag;
        @(posedge pclk) disable iff (!presetn)
        // A reset inside the window empties the chain, so only clean windows are judged
        $past(presetn) && $past(presetn, SYNC_STAGES) |-> sif.sync == $past(sif.raw, SYNC_STAGES);
    endproperty
    a_sync_lag: assert property (p_sync_lag) else $error("input not synchronised in two cycles");
endmodule // scis_sync

// ### hw/scis_sync_if.sv
`timescale 1ns/1ps
// Raw digital inputs in, synchronised copies out
interface scis_sync_if #(parameter int N = 5);
    logic [N-1:0] raw;
    logic [N-1:0] sync;
    modport core (output raw, input sync);
    modport sync_side (input raw, output sync);
endinterface

// ### testbench/scis_host_model.sv
`timescale 1ns/1ps
// Host controller side: digital command levels and converted analog values
module scis_host_model #(
    parameter int AW = 16
) (
    input wire logic pclk,
    output logic [scis_pkg::N_INPUTS-1:0] din,
    output logic signed [AW-1:0] ai_one,
    output logic signed [AW-1:0] ai_two,
    output logic signed [AW-1:0] ai_three
);
    import scis_pkg::*;
    // Idle host: all command inputs off, analog inputs at zero volts
    initial begin
        din = '0;
        ai_one = '0;
        ai_two = '0;
        ai_three = '0;
    end
    // Levels change just after an edge; the drive resynchronises them anyway
    task automatic set(input logic [N_INPUTS-1:0] d, input logic signed [AW-1:0] x1,
                       input logic signed [AW-1:0] x2, input logic signed [AW-1:0] x3);
        din <= d;
        ai_one <= x1;
        ai_two <= x2;
        ai_three <= x3;
    endtask
endmodule // scis_host_model

// ### testbench/tb_servo_command_input_select.sv
`timescale 1ns/1ps
module tb_servo_command_input_select;
    import scis_pkg::*;
    localparam int AW = 16;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [N_INPUTS-1:0] din;
    logic signed [AW-1:0] a1, a2, a3, spd, trq, slim, ptl, ntl;
    logic lfp, inr2, alarm;
    logic [15:0] acode;
    logic signed [AW-1:0] exp_p, exp_n;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
    ////////////////////////////////////////////////////////////////////////
    scis_host_model #(.AW(AW)) host (.pclk(pclk), .din(din), .ai_one(a1), .ai_two(a2), .ai_three(a3));
    scis_cmd_select #(.AW(AW)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .zero_speed_clamp(din[IN_CLAMP]), .speed_sign_input(din[IN_SSIGN]),
        .torque_sign_input(din[IN_TSIGN]), .forced_alarm_input(din[IN_ALARM]),
        .inertia_select_input(din[IN_INERTIA]), .analog_input_one(a1), .analog_input_two(a2),
        .analog_input_three(a3), .speed_command(spd), .torque_command(trq), .speed_limit(slim),
        .positive_torque_limit(ptl), .negative_torque_limit(ntl), .limit_from_param(lfp),
        .second_inertia_ratio(inr2), .forced_alarm_error(alarm), .alarm_code(acode));
    ////////////////////////////////////////////////////////////////////////
    // Free-running bus clock, 8 ns period
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One APB transfer; entered right after an edge, leaves one idle edge after it
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [31:0] cfg(int zcs, int tls, int sg, int tm, int f1, int t2);
        return 32'((zcs << CFG_ZCS_LSB) | (tls << CFG_TLS_LSB) | (sg << CFG_SIGN_EN_BIT)
            | (tm << CFG_TORQUE_MODE_BIT) | (f1 << CFG_SRC1_LSB) | (t2 << CFG_SRC2_BIT));
    endfunction
    // Pin changes need two sync flops and the output register
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        `CHK(rd, CONFIG_RESET)
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        `CHK(err, 1'b1)
        apb(1'b1, ADDR_CONFIG, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        `CHK(rd, CONFIG_MASK)
        $display("test registers done");
        // Clamp ignored while its select is zero, effective once nonzero
        apb(1'b1, ADDR_CONFIG, cfg(0, 0, 0, 0, 0, 0));
        host.set(5'h01, 16'sh0064, 16'sh0000, 16'sh0000);
        settle();
        `CHK(spd, 16'sh0064)
        apb(1'b1, ADDR_CONFIG, cfg(1, 0, 0, 0, 0, 0));
        settle();
        `CHK(spd, 16'sh0000)
        $display("test clamp done");
        // Speed sign: ON gives the negative direction
        apb(1'b1, ADDR_CONFIG, cfg(0, 0, 1, 0, 0, 0));
        host.set(5'h02, -16'sh0064, 16'sh0000, 16'sh0000);
        settle();
        `CHK(spd, -16'sh0064)
        host.set(5'h00, -16'sh0064, 16'sh0000, 16'sh0000);
        settle();
        `CHK(spd, 16'sh0064)
        $display("test speed sign done");
        // Torque sign from either torque source, plus speed limit routing
        apb(1'b1, ADDR_CONFIG, cfg(0, 0, 0, 1, SRC1_TORQUE, 0));
        host.set(5'h04, -16'sh0032, 16'sh0000, 16'sh0000);
        settle();
        `CHK(trq, -16'sh0032)
        host.set(5'h00, -16'sh0032, 16'sh0000, 16'sh0000);
        settle();
        `CHK(trq, 16'sh0032)
        apb(1'b1, ADDR_CONFIG, cfg(0, 0, 0, 1, SRC1_SPEED_LIMIT, 1));
        host.set(5'h04, -16'sh0028, 16'sh0046, 16'sh0000);
        settle();
        `CHK(trq, -16'sh0046)
        `CHK(slim, 16'sh0028)
        $display("test torque done");
        // Forced alarm is sticky while the input stays on
        host.set(5'h08, 16'sh0000, 16'sh0000, 16'sh0000);
        settle();
        `CHK(alarm, 1'b1)
        `CHK(acode, {ALARM_MAIN_CODE, ALARM_SUB_CODE})
        apb(1'b1, ADDR_ALARM_CLR, 32'h0000_0001);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        `CHK(rd, 32'h5700_0108)
        host.set(5'h10, 16'sh0000, 16'sh0000, 16'sh0000);
        settle();
        apb(1'b1, ADDR_ALARM_CLR, 32'h0000_0001);
        settle();
        `CHK(alarm, 1'b0)
        `CHK(acode, 16'h0000)
        `CHK(inr2, 1'b1)
        host.set(5'h00, 16'sh0000, 16'sh0000, 16'sh0000);
        settle();
        `CHK(inr2, 1'b0)
        $display("test alarm and inertia done");
        // Every limit source code
        host.set(5'h00, 16'sh0000, 16'sh00C8, -16'sh012C);
        for (int t = 0; t < 8; t++) begin
            apb(1'b1, ADDR_CONFIG, cfg(0, t, 0, 0, 0, 0));
            settle();
            exp_p = (t == 0 || t == 4 || t == 5) ? 16'sh00C8 : 16'sh0000;
            exp_n = (t == 0) ? 16'sh012C : (t == 5) ? 16'sh00C8 : 16'sh0000;
            `CHK(ptl, exp_p)
            `CHK(ntl, exp_n)
            `CHK(lfp, (exp_p == 0) ? 1'b1 : 1'b0)
        end
        $display("test limit source done");
        // Positive third input on the unipolar source, then a mid-run reset must clear it
        host.set(5'h00, 16'sh0000, 16'sh00C8, 16'sh012C);
        apb(1'b1, ADDR_CONFIG, cfg(0, TLS_UNIPOLAR, 0, 0, 0, 0));
        settle();
        `CHK(ntl, 16'sh012C)
        `CHK(ptl, 16'sh00C8)
        presetn <= 1'b0;
        @(posedge pclk);
        `CHK(ntl, 16'sh0000)
        `CHK(ptl, 16'sh0000)
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        `CHK(rd, CONFIG_RESET)
        $display("test reset done");
        tally_and_finish();
    end
endmodule // tb_servo_command_input_select
